// >>> sad_defs.vh
`ifndef SAD_DEFS_VH
`define SAD_DEFS_VH

// Target select bit positions.
`define SAD_T_PMEM 0
`define SAD_T_DMEM 1
`define SAD_T_XMEM 2
`define SAD_T_GCR 3
`define SAD_T_CLK 4
`define SAD_T_IMUX 5
`define SAD_T_PORT 6
`define SAD_T_PMC 7
`define SAD_T_XBIC 8
`define SAD_T_WDOG 9
`define SAD_T_TMR01 10
`define SAD_T_TWI 11
`define SAD_T_SPIA 12
`define SAD_T_SPIB 13
`define SAD_T_PWMA 14
`define SAD_T_UARTA 15
`define SAD_T_ACMP 16
`define SAD_T_ADC 17
`define SAD_T_TMR23 18
`define SAD_T_PWMB 19
`define SAD_T_UARTB 20
`define SAD_T_TICK 21
`define SAD_T_NVIC 22
`define SAD_T_SCR 23
`define SAD_NTGT 24

// Window base and last addresses.
`define SAD_PMEM_LO 32'h0000_0000
`define SAD_PMEM_HI 32'h0000_ffff
`define SAD_DMEM_LO 32'h2000_0000
`define SAD_DMEM_HI 32'h2000_0fff
`define SAD_XMEM_LO 32'h6000_0000
`define SAD_XMEM_HI 32'h6001_ffff
`define SAD_AHB_LO 32'h5000_0000
`define SAD_AHB_HI 32'h501f_ffff
`define SAD_GCR_LO 32'h5000_0000
`define SAD_GCR_HI 32'h5000_01ff
`define SAD_CLK_LO 32'h5000_0200
`define SAD_CLK_HI 32'h5000_02ff
`define SAD_IMUX_LO 32'h5000_0300
`define SAD_IMUX_HI 32'h5000_03ff
`define SAD_PORT_LO 32'h5000_4000
`define SAD_PORT_HI 32'h5000_7fff
`define SAD_PMC_LO 32'h5000_c000
`define SAD_PMC_HI 32'h5000_ffff
`define SAD_XBIC_LO 32'h5001_0000
`define SAD_XBIC_HI 32'h5001_03ff
`define SAD_APB_LO 32'h4000_0000
`define SAD_APB_HI 32'h400f_ffff
`define SAD_WDOG_LO 32'h4000_4000
`define SAD_TMR01_LO 32'h4001_0000
`define SAD_TWI_LO 32'h4002_0000
`define SAD_SPIA_LO 32'h4003_0000
`define SAD_SPIB_LO 32'h4003_4000
`define SAD_PWMA_LO 32'h4004_0000
`define SAD_UARTA_LO 32'h4005_0000
`define SAD_ACMP_LO 32'h400d_0000
`define SAD_ADC_LO 32'h400e_0000
`define SAD_ADC_HI 32'h400e_ffff
`define SAD_TMR23_LO 32'h4011_0000
`define SAD_PWMB_LO 32'h4014_0000
`define SAD_UARTB_LO 32'h4015_0000
`define SAD_WIN16K 32'h0000_3fff
`define SAD_TICK_LO 32'he000_e010
`define SAD_TICK_HI 32'he000_e0ff
`define SAD_NVIC_LO 32'he000_e100
`define SAD_NVIC_HI 32'he000_ecff
`define SAD_SCR_LO 32'he000_ed00
`define SAD_SCR_HI 32'he000_ed8f

// Reset cause flag positions.
`define SAD_RC_POR 0
`define SAD_RC_PIN 1
`define SAD_RC_WDOG 2
`define SAD_RC_LOWV 3
`define SAD_RC_BOD 4
`define SAD_RC_CPU 5
`define SAD_RC_SW 6
`define SAD_NRC 7

// AHB transfer and response codes.
`define SAD_HTRANS_NSEQ 2'h2
`define SAD_HRESP_OKAY 1'h0
`define SAD_HRESP_ERROR 1'h1

`endif

// >>> sad_window.v
`timescale 1ns/100ps
`default_nettype none

// One address window compare: hit when the address lies in [LO, HI].
module sad_window #(
	parameter [31:0] LO = 32'h0000_0000,
	parameter [31:0] HI = 32'h0000_0000
) (
	// Address in.
	input wire [31:0] i_addr,
	// Hit out.
	output wire o_hit
);

	// Both bounds are inclusive so printed last addresses can be used directly.
	assign o_hit = (i_addr >= LO) && (i_addr <= HI);

endmodule

`default_nettype wire

// >>> sad_decoder.v
`timescale 1ns/100ps
`default_nettype none
`include "sad_defs.vh"

module sad_decoder (
	// Clock and reset.
	input wire i_clk_sys,
	input wire i_rst_n,
	// AHB-Lite slave side from the processor.
	input wire i_hsel,
	input wire [31:0] i_haddr,
	input wire [1:0] i_htrans,
	input wire i_hready,
	output wire o_hreadyout,
	output wire o_hresp,
	// Target data phase ready and response, one bit per target.
	input wire [`SAD_NTGT-1:0] i_tgt_hreadyout,
	input wire [`SAD_NTGT-1:0] i_tgt_hresp,
	// Address phase selects and data phase owner.
	output wire [`SAD_NTGT-1:0] o_tgt_sel,
	output wire [`SAD_NTGT-1:0] o_tgt_dsel,
	output wire o_ahb_region,
	output wire o_apb_region,
	// Reset cause event pulses from the reset sources, asynchronous.
	input wire [`SAD_NRC-1:0] i_rst_event,
	input wire [`SAD_NRC-1:0] i_rc_clear,
	output wire [`SAD_NRC-1:0] o_reset_cause_flags,
	// Fixed byte order indication.
	output wire o_big_endian
);

	wire [`SAD_NTGT-1:0] hit;
	wire in_ahb;
	wire in_apb;
	wire req;
	wire unmapped;
	reg [`SAD_NTGT-1:0] dsel_reg;
	reg [1:0] err_state_reg;
	reg [1:0] err_state_next;
	reg [`SAD_NRC-1:0] rc_sync1_reg;
	reg [`SAD_NRC-1:0] rc_sync2_reg;
	reg [`SAD_NRC-1:0] rc_flags_reg;

	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_ERR1 = 2'h1;
	localparam [1:0] ST_ERR2 = 2'h2;

	// Memory windows.
	sad_window #(.LO(`SAD_PMEM_LO), .HI(`SAD_PMEM_HI)) u_pmem (.i_addr(i_haddr), .o_hit(hit[`SAD_T_PMEM]));
	sad_window #(.LO(`SAD_DMEM_LO), .HI(`SAD_DMEM_HI)) u_dmem (.i_addr(i_haddr), .o_hit(hit[`SAD_T_DMEM]));
	sad_window #(.LO(`SAD_XMEM_LO), .HI(`SAD_XMEM_HI)) u_xmem (.i_addr(i_haddr), .o_hit(hit[`SAD_T_XMEM]));

	// AHB peripheral region and its banks.
	sad_window #(.LO(`SAD_AHB_LO), .HI(`SAD_AHB_HI)) u_ahb (.i_addr(i_haddr), .o_hit(in_ahb));
	sad_window #(.LO(`SAD_GCR_LO), .HI(`SAD_GCR_HI)) u_gcr (.i_addr(i_haddr), .o_hit(hit[`SAD_T_GCR]));
	sad_window #(.LO(`SAD_CLK_LO), .HI(`SAD_CLK_HI)) u_clk (.i_addr(i_haddr), .o_hit(hit[`SAD_T_CLK]));
	sad_window #(.LO(`SAD_IMUX_LO), .HI(`SAD_IMUX_HI)) u_imux (.i_addr(i_haddr), .o_hit(hit[`SAD_T_IMUX]));
	sad_window #(.LO(`SAD_PORT_LO), .HI(`SAD_PORT_HI)) u_port (.i_addr(i_haddr), .o_hit(hit[`SAD_T_PORT]));
	sad_window #(.LO(`SAD_PMC_LO), .HI(`SAD_PMC_HI)) u_pmc (.i_addr(i_haddr), .o_hit(hit[`SAD_T_PMC]));
	sad_window #(.LO(`SAD_XBIC_LO), .HI(`SAD_XBIC_HI)) u_xbic (.i_addr(i_haddr), .o_hit(hit[`SAD_T_XBIC]));

	// APB region behind the bridge; each bank is a 16 KB window except ADC, which spans 64 KB.
	sad_window #(.LO(`SAD_APB_LO), .HI(`SAD_APB_HI)) u_apb (.i_addr(i_haddr), .o_hit(in_apb));
	sad_window #(.LO(`SAD_WDOG_LO), .HI(`SAD_WDOG_LO + `SAD_WIN16K)) u_wdog (
		.i_addr(i_haddr),
		.o_hit(hit[`SAD_T_WDOG])
	);
	sad_window #(.LO(`SAD_TMR01_LO), .HI(`SAD_TMR01_LO + `SAD_WIN16K)) u_tmr01 (
		.i_addr(i_haddr),
		.o_hit(hit[`SAD_T_TMR01])
	);
	sad_window #(.LO(`SAD_TWI_LO), .HI(`SAD_TWI_LO + `SAD_WIN16K)) u_twi (
		.i_addr(i_haddr),
		.o_hit(hit[`SAD_T_TWI])
	);
	sad_window #(.LO(`SAD_SPIA_LO), .HI(`SAD_SPIA_LO + `SAD_WIN16K)) u_spia (
		.i_addr(i_haddr),
		.o_hit(hit[`SAD_T_SPIA])
	);
	sad_window #(.LO(`SAD_SPIB_LO), .HI(`SAD_SPIB_LO + `SAD_WIN16K)) u_spib (
		.i_addr(i_haddr),
		.o_hit(hit[`SAD_T_SPIB])
	);
	sad_window #(.LO(`SAD_PWMA_LO), .HI(`SAD_PWMA_LO + `SAD_WIN16K)) u_pwma (
		.i_addr(i_haddr),
		.o_hit(hit[`SAD_T_PWMA])
	);
	sad_window #(.LO(`SAD_UARTA_LO), .HI(`SAD_UARTA_LO + `SAD_WIN16K)) u_uarta (
		.i_addr(i_haddr),
		.o_hit(hit[`SAD_T_UARTA])
	);
	sad_window #(.LO(`SAD_ACMP_LO), .HI(`SAD_ACMP_LO + `SAD_WIN16K)) u_acmp (
		.i_addr(i_haddr),
		.o_hit(hit[`SAD_T_ACMP])
	);
	sad_window #(.LO(`SAD_ADC_LO), .HI(`SAD_ADC_HI)) u_adc (.i_addr(i_haddr), .o_hit(hit[`SAD_T_ADC]));
	sad_window #(.LO(`SAD_TMR23_LO), .HI(`SAD_TMR23_LO + `SAD_WIN16K)) u_tmr23 (
		.i_addr(i_haddr),
		.o_hit(hit[`SAD_T_TMR23])
	);
	sad_window #(.LO(`SAD_PWMB_LO), .HI(`SAD_PWMB_LO + `SAD_WIN16K)) u_pwmb (
		.i_addr(i_haddr),
		.o_hit(hit[`SAD_T_PWMB])
	);
	sad_window #(.LO(`SAD_UARTB_LO), .HI(`SAD_UARTB_LO + `SAD_WIN16K)) u_uartb (
		.i_addr(i_haddr),
		.o_hit(hit[`SAD_T_UARTB])
	);

	// Private system control space.
	sad_window #(.LO(`SAD_TICK_LO), .HI(`SAD_TICK_HI)) u_tick (.i_addr(i_haddr), .o_hit(hit[`SAD_T_TICK]));
	sad_window #(.LO(`SAD_NVIC_LO), .HI(`SAD_NVIC_HI)) u_nvic (.i_addr(i_haddr), .o_hit(hit[`SAD_T_NVIC]));
	sad_window #(.LO(`SAD_SCR_LO), .HI(`SAD_SCR_HI)) u_scr (.i_addr(i_haddr), .o_hit(hit[`SAD_T_SCR]));

	// A transfer is taken only when it is selected, non-idle and the bus is ready.
	assign req = i_hsel && i_htrans[1] && i_hready;

	// Windows never overlap, so at most one select is high in an address phase.
	assign o_tgt_sel = req ? hit : {`SAD_NTGT{1'b0}};
	assign unmapped = req && (hit == {`SAD_NTGT{1'b0}});

	// Region flags show which bus fabric carries the current address phase.
	assign o_ahb_region = req && in_ahb;
	assign o_apb_region = req && in_apb;

	// Data phase owner; it only moves while the bus is ready, as AHB requires.
	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			dsel_reg <= {`SAD_NTGT{1'b0}};
		end else if (i_hready) begin
			dsel_reg <= o_tgt_sel;
		end
	end
	assign o_tgt_dsel = dsel_reg;

	// Error answer is the two-cycle AHB error: low ready then high ready, both with error.
	always @* begin
		err_state_next = err_state_reg;
		case (err_state_reg)
			ST_IDLE: begin
				if (unmapped) begin
					err_state_next = ST_ERR1;
				end
			end
			ST_ERR1: begin
				err_state_next = ST_ERR2;
			end
			ST_ERR2: begin
				err_state_next = unmapped ? ST_ERR1 : ST_IDLE;
			end
			default: begin
				err_state_next = ST_IDLE;
			end
		endcase
	end

	always @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			err_state_reg <= ST_IDLE;
		end else begin
			err_state_reg <= err_state_next;
		end
	end

	// Error phase overrides target answers; with no owner the slave idles ready and okay.
	assign o_hreadyout = (err_state_reg == ST_ERR1) ? 1'b0 :
		(err_state_reg == ST_ERR2) ? 1'b1 :
		(dsel_reg == {`SAD_NTGT{1'b0}}) ? 1'b1 : |(dsel_reg & i_tgt_hreadyout);
	assign o_hresp = (err_state_reg != ST_IDLE) ? `SAD_HRESP_ERROR :
		(dsel_reg == {`SAD_NTGT{1'b0}}) ? `SAD_HRESP_OKAY : |(dsel_reg & i_tgt_hresp);

	// Only little-endian is built; the strap is tied so no path swaps byte lanes.
	assign o_big_endian = 1'b0;

	// Reset causes arrive from other logic and pins, so they pass two flip-flops first.
	// The pair has no reset: a cause that pulls the system reset must still reach its flag.
	always @(posedge i_clk_sys) begin
		rc_sync1_reg <= i_rst_event;
		rc_sync2_reg <= rc_sync1_reg;
	end

	// Flags live in the always-on domain and are not cleared by the system reset itself,
	// since the cause would otherwise be lost. A new event wins over a clear.
	always @(posedge i_clk_sys) begin
		rc_flags_reg <= (rc_flags_reg & ~i_rc_clear) | rc_sync2_reg;
	end
	assign o_reset_cause_flags = rc_flags_reg;

endmodule

`default_nettype wire

// >>> sad_chk.sv
`timescale 1ns/100ps
`default_nettype none
`include "sad_defs.vh"
module sad_chk (
	// Clock and reset.
	input wire logic i_clk_sys,
	input wire logic i_rst_n,
	// Bus side.
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hready,
	input wire logic o_hreadyout,
	input wire logic o_hresp,
	// Target side.
	input wire logic [`SAD_NTGT-1:0] i_tgt_hreadyout,
	input wire logic [`SAD_NTGT-1:0] i_tgt_hresp,
	input wire logic [`SAD_NTGT-1:0] o_tgt_sel,
	input wire logic [`SAD_NTGT-1:0] o_tgt_dsel,
	input wire logic o_ahb_region,
	input wire logic o_apb_region,
	// Reset causes and byte order.
	input wire logic [`SAD_NRC-1:0] i_rst_event,
	input wire logic [`SAD_NRC-1:0] i_rc_clear,
	input wire logic [`SAD_NRC-1:0] o_reset_cause_flags,
	input wire logic o_big_endian
);
	// One clock domain, so one default clock and reset serve every check.
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);
	wire logic take = i_hsel && i_htrans[1] && i_hready;
	unmapped_err_a: assert property (take && o_tgt_sel == 0 |=> !o_hreadyout && o_hresp ##1 o_hreadyout && o_hresp)
		else $error("unmapped access without two-cycle error");
	pmem_sel_a: assert property (take && i_haddr[31:16] == 16'h0 |-> o_tgt_sel == 24'h1)
		else $error("program memory not selected");
	dmem_sel_a: assert property (take && i_haddr[31:12] == 20'h20000 |-> o_tgt_sel == 24'h2)
		else $error("data memory not selected");
	tick_sel_a: assert property (take && i_haddr >= 32'he000e010 && i_haddr <= 32'he000e0ff |-> o_tgt_sel[`SAD_T_TICK])
		else $error("tick timer not selected");
	dsel_follow_a: assert property (take |=> o_tgt_dsel == $past(o_tgt_sel))
		else $error("data phase owner differs from address select");
	ready_mux_a: assert property (o_tgt_dsel != 0 |-> o_hreadyout == |(o_tgt_dsel & i_tgt_hreadyout))
		else $error("ready not taken from owning target");
	region_flag_a: assert property (take |-> o_ahb_region == (i_haddr[31:21] == 11'h280))
		else $error("fast peripheral region flag wrong");
	little_end_a: assert property (!o_big_endian)
		else $error("big-endian indicated");
	flag_set_a: assert property (i_rst_event[`SAD_RC_WDOG] [*2] |-> ##2 o_reset_cause_flags[`SAD_RC_WDOG])
		else $error("reset cause flag not set");
	flag_clr_a: assert property ((i_rst_event == 7'h0) [*3] ##0 i_rc_clear == 7'h7f |=> o_reset_cause_flags == 7'h0)
		else $error("reset cause flags not cleared");
	// Main scenarios that the bench must reach.
	cover property (take && o_tgt_sel == 0);
	cover property (o_tgt_dsel != 0 && !o_hreadyout);
	cover property (i_rst_event != 0 && i_rc_clear != 0);
endmodule
bind sad_decoder sad_chk chk_u (.*);
`default_nettype wire

// >>> sad_mst.sv
`timescale 1ns/100ps
`default_nettype none
module sad_mst (
	// Clock and ready from the decoder.
	input wire logic i_clk_sys,
	input wire logic i_hready,
	// Address phase out.
	output logic o_hsel,
	output logic [31:0] o_haddr,
	output logic [1:0] o_htrans
);
	initial begin
		o_hsel = 1'b0;
		o_haddr = 32'h0;
		o_htrans = 2'h0;
	end
	// One word transfer, held until ready is seen at an edge; no big-endian lanes are ever asked for.
	task xfer(input logic [31:0] a);
		o_hsel <= 1'b1;
		o_htrans <= 2'h2;
		o_haddr <= a;
		do @(negedge i_clk_sys); while (!i_hready);
		@(posedge i_clk_sys);
	endtask
	// Released address shows its inverse, so a stale value cannot decode by luck.
	task idle();
		o_hsel <= 1'b0;
		o_htrans <= 2'h0;
		o_haddr <= ~o_haddr;
		@(posedge i_clk_sys);
	endtask
endmodule
`default_nettype wire

// >>> sad_decoder_tb.sv
`timescale 1ns/100ps
`default_nettype none
module sad_decoder_tb;
	localparam logic [31:0] LO [24] = '{32'h0, 32'h20000000, 32'h60000000, 32'h50000000, 32'h50000200, 32'h50000300,
		32'h50004000, 32'h5000c000, 32'h50010000, 32'h40004000, 32'h40010000, 32'h40020000, 32'h40030000,
		32'h40034000, 32'h40040000, 32'h40050000, 32'h400d0000, 32'h400e0000, 32'h40110000, 32'h40140000,
		32'h40150000, 32'he000e010, 32'he000e100, 32'he000ed00};
	localparam logic [31:0] HI [24] = '{32'hffff, 32'h20000fff, 32'h6001ffff, 32'h500001ff, 32'h500002ff, 32'h500003ff,
		32'h50007fff, 32'h5000ffff, 32'h500103ff, 32'h40007fff, 32'h40013fff, 32'h40023fff, 32'h40033fff,
		32'h40037fff, 32'h40043fff, 32'h40053fff, 32'h400d3fff, 32'h400effff, 32'h40113fff, 32'h40143fff,
		32'h40153fff, 32'he000e0ff, 32'he000ecff, 32'he000ed8f};
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] lfsr = 32'h8b508670;
	logic [23:0] t_rdy = 24'hffffff;
	logic [23:0] t_resp = 24'h0;
	logic [6:0] ev = 7'h0;
	logic [6:0] clr = 7'h0;
	logic [6:0] exp_f = 7'h0;
	logic tk = 1'b0;
	wire logic hsel, hrdy, hresp, ahb, apb, big;
	wire logic [31:0] haddr;
	wire logic [1:0] htrans;
	wire logic [23:0] sel, dsel;
	wire logic [6:0] flags;
	int errors = 0;
	int checked = 0;
	int cyc = 0;
	int dp = -2;
	int ec = 0;
	always #20 clk = ~clk;
	sad_mst mst_u (.i_clk_sys(clk), .i_hready(hrdy), .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans));
	sad_decoder dut_u (.i_clk_sys(clk), .i_rst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
		.i_hready(hrdy), .o_hreadyout(hrdy), .o_hresp(hresp), .i_tgt_hreadyout(t_rdy), .i_tgt_hresp(t_resp),
		.o_tgt_sel(sel), .o_tgt_dsel(dsel), .o_ahb_region(ahb), .o_apb_region(apb), .i_rst_event(ev),
		.i_rc_clear(clr), .o_reset_cause_flags(flags), .o_big_endian(big));
	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
	endfunction
	// Window table lookup; -1 means a reserved hole.
	function automatic int tgt(input logic [31:0] a);
		for (int k = 0; k < 24; k++) if (a >= LO[k] && a <= HI[k]) return k;
		return -1;
	endfunction
	task cmp(input string n, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e) begin
			errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task end_of_test();
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Targets stall and answer at random; a hang is cut short by the cycle ceiling.
	always @(posedge clk) begin
		lfsr <= nx(lfsr);
		t_rdy <= lfsr[23:0] | lfsr[31:8];
		t_resp <= lfsr[23:0] & lfsr[31:8] & lfsr[30:7];
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			end_of_test();
		end
	end
	// Reference model at the falling edge, where every input has settled.
	always @(negedge clk) begin
		if (!rst_n) dp = -2;
		else begin
			// Only a transfer that meets a ready bus is taken; a stalled one selects nothing yet.
			tk = hsel && htrans[1] && hrdy;
			cmp("sel", (tk && tgt(haddr) >= 0) ? 32'h1 << tgt(haddr) : 32'h0, sel);
			cmp("ahb", tk && haddr[31:21] == 11'h280, ahb);
			cmp("apb", tk && haddr[31:20] == 12'h400, apb);
			if (dp >= 0) begin
				cmp("dsel", 32'h1 << dp, dsel);
				cmp("rdy", t_rdy[dp], hrdy);
				cmp("resp", t_resp[dp], hresp);
			end else if (dp == -1) begin
				cmp("edsel", 0, dsel);
				cmp("erdy", ec, hrdy);
				cmp("eresp", 1, hresp);
			end else begin
				cmp("idsel", 0, dsel);
				cmp("irdy", 1, hrdy);
				cmp("iresp", 0, hresp);
			end
			if (hrdy) dp = tk ? tgt(haddr) : -2;
			ec = hrdy ? 0 : 1;
		end
	end
	// Reset, reset causes, then every window at both edges and just past its end, then random traffic.
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		clr <= 7'h7f;
		@(posedge clk);
		clr <= 7'h0;
		for (int k = 0; k < 7; k++) begin
			ev <= 7'h1 << k;
			repeat (3) @(posedge clk);
			ev <= 7'h0;
			exp_f[k] = 1'b1;
			repeat (3) @(posedge clk);
			#1 cmp("flags", exp_f, flags);
		end
		ev <= 7'h1;
		clr <= 7'h7f;
		repeat (3) @(posedge clk);
		#1 cmp("setwins", 7'h1, flags);
		ev <= 7'h0;
		repeat (4) @(posedge clk);
		#1 cmp("cleared", 7'h0, flags);
		clr <= 7'h0;
		@(posedge clk);
		for (int k = 0; k < 24; k++) begin
			mst_u.xfer(LO[k]);
			mst_u.xfer(HI[k]);
			mst_u.xfer(HI[k] + 32'h1);
		end
		mst_u.xfer(32'he000e000);
		repeat (60) begin
			mst_u.xfer(LO[lfsr[4:0] % 24] ^ {18'h0, lfsr[13:0]});
			if (lfsr[20]) mst_u.idle();
		end
		mst_u.idle();
		repeat (3) @(posedge clk);
		cmp("big", 0, big);
		end_of_test();
	end
endmodule
`default_nettype wire
